/* File: hw/ptss_regs.sv */
// status registers of the second loop pll autotune and the frame
// reference generator, with the frame reference step sequencer.
// assumes all status inputs come from logic on core_clk.
//
// Functional notes
// - A finished autotune run loads the cap bank register with its vco bank.
// - The low error byte shows bits 7:0 of the 14-bit tuning-voltage error.
// - Bits 5:0 of the tune status register show bits 13:8 of the error count.
// - Tune status bit 7 is the autotune busy flag, bit 6 the error sign.
// - Bits 7:4 of the state register report the autotune state machine code.
// - Bits 3:0 of the state register show the sync-carry state machine code.
// - Frame reference status bit 4 is 1 while a channel output machine runs.
// - Frame reference status bits 3:0 show the frame reference sequencer step.
// - The sequencer takes one of three progressions set by its trigger.
`timescale 1ns/100ps
`include "ptss_map.svh"

module ptss_regs #(
  parameter int STEP_DIV = `PTSS_STEP_DIV
) (
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic reg_rd_en,
  input wire logic reg_wr_en,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data_q,
  output logic reg_rd_valid_q,
  // tune engine
  input wire logic tune_done,
  input wire ptss_pkg::ptss_tune_result_t tune_result,
  input wire ptss_pkg::ptss_tune_live_t tune_live,
  // clock distribution
  input wire logic channel_busy,
  // frame reference triggers and pulse generator end
  input wire logic reseed_req,
  input wire logic pulse_req,
  input wire logic rsvd_req,
  input wire logic pulse_finished,
  output logic [3:0] frame_ref_step_q
);

  // ================================================================
  // step code for each sequencer state
  function automatic logic [3:0] step_code(ptss_pkg::ptss_fr_state_t s);
    logic [3:0] c;
    c = `PTSS_CODE_RESET;
    case (s)
      ptss_pkg::FR_DONE: c = `PTSS_CODE_DONE;
      ptss_pkg::FR_GET0: c = `PTSS_CODE_GET0;
      ptss_pkg::FR_GET1: c = `PTSS_CODE_GET1;
      ptss_pkg::FR_GET2: c = `PTSS_CODE_GET2;
      ptss_pkg::FR_RUN: c = `PTSS_CODE_RUN;
      ptss_pkg::FR_START: c = `PTSS_CODE_START;
      ptss_pkg::FR_PWR0: c = `PTSS_CODE_PWR0;
      ptss_pkg::FR_PWR1: c = `PTSS_CODE_PWR1;
      ptss_pkg::FR_PWR2: c = `PTSS_CODE_PWR2;
      ptss_pkg::FR_CLEAR: c = `PTSS_CODE_CLEAR;
      default: c = `PTSS_CODE_RESET;
    endcase
    return c;
  endfunction

  // ================================================================
  // captured and sampled status
  logic [7:0] cap_bank_q;
  logic err_sign_q;
  logic [13:0] err_count_q;
  ptss_pkg::ptss_tune_live_t live_q;
  logic ch_busy_q;

  // the result is held between runs so software can read it at leisure
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cap_bank_q <= `PTSS_RST_BYTE;
      err_sign_q <= 1'b0;
      err_count_q <= `PTSS_RST_ERR;
    end else if (tune_done) begin
      cap_bank_q <= tune_result.cap_bank;
      err_sign_q <= tune_result.err_sign;
      err_count_q <= tune_result.err_count;
    end
  end

  // live flags sampled each cycle, one cycle behind their source
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      live_q <= '0;
      ch_busy_q <= 1'b0;
    end else begin
      live_q <= tune_live;
      ch_busy_q <= channel_busy;
    end
  end

  // ================================================================
  // step rate divider: one-cycle enable every STEP_DIV cycles
  logic [7:0] div_q;
  logic step_en;

  assign step_en = (div_q == 8'(STEP_DIV - 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_q <= 8'h00;
    end else if (step_en) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ================================================================
  // frame reference sequencer
  ptss_pkg::ptss_fr_state_t fr_q;
  ptss_pkg::ptss_fr_state_t fr_d;
  ptss_pkg::ptss_trig_t trig_q;
  logic pulse_seen_q;

  // triggers only start a progression from rest; reseed has priority,
  // then the pulse generator, so a collision picks one path
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trig_q <= ptss_pkg::TRIG_RSVD;
    end else if (fr_q == ptss_pkg::FR_RESET) begin
      if (reseed_req) begin
        trig_q <= ptss_pkg::TRIG_RESEED;
      end else if (pulse_req) begin
        trig_q <= ptss_pkg::TRIG_PULSE;
      end else if (rsvd_req) begin
        trig_q <= ptss_pkg::TRIG_RSVD;
      end
    end
  end

  // the pulse end is caught sticky so it is not lost between steps;
  // a new end outranks the clear applied in every step but the running one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pulse_seen_q <= 1'b0;
    end else if (pulse_finished) begin
      pulse_seen_q <= 1'b1;
    end else if (fr_q != ptss_pkg::FR_RUN) begin
      pulse_seen_q <= 1'b0;
    end
  end

  // next state: leaving rest is immediate, later steps wait on step_en
  always_comb begin
    fr_d = fr_q;
    case (fr_q)
      ptss_pkg::FR_RESET: begin
        if (reseed_req || pulse_req || rsvd_req) begin
          fr_d = ptss_pkg::FR_GET0;
        end
      end
      ptss_pkg::FR_GET0: begin
        if (step_en) fr_d = ptss_pkg::FR_GET1;
      end
      ptss_pkg::FR_GET1: begin
        if (step_en) fr_d = ptss_pkg::FR_GET2;
      end
      ptss_pkg::FR_GET2: begin
        if (step_en) begin
          case (trig_q)
            ptss_pkg::TRIG_RESEED: fr_d = ptss_pkg::FR_PWR0;
            ptss_pkg::TRIG_PULSE: fr_d = ptss_pkg::FR_START;
            default: fr_d = ptss_pkg::FR_DONE;
          endcase
        end
      end
      ptss_pkg::FR_PWR0: begin
        if (step_en) fr_d = ptss_pkg::FR_PWR1;
      end
      ptss_pkg::FR_PWR1: begin
        if (step_en) fr_d = ptss_pkg::FR_PWR2;
      end
      ptss_pkg::FR_PWR2: begin
        if (step_en) fr_d = ptss_pkg::FR_CLEAR;
      end
      ptss_pkg::FR_CLEAR: begin
        if (step_en) fr_d = ptss_pkg::FR_START;
      end
      ptss_pkg::FR_START: begin
        if (step_en) begin
          if (trig_q == ptss_pkg::TRIG_PULSE) begin
            fr_d = ptss_pkg::FR_RUN;
          end else begin
            fr_d = ptss_pkg::FR_DONE;
          end
        end
      end
      ptss_pkg::FR_RUN: begin
        // held as long as the pulse generator runs
        if (step_en && pulse_seen_q) fr_d = ptss_pkg::FR_DONE;
      end
      ptss_pkg::FR_DONE: begin
        if (step_en) fr_d = ptss_pkg::FR_RESET;
      end
      default: fr_d = ptss_pkg::FR_RESET;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fr_q <= ptss_pkg::FR_RESET;
    end else begin
      fr_q <= fr_d;
    end
  end

  // step code out, from a flop like every other output
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame_ref_step_q <= `PTSS_CODE_RESET;
    end else begin
      frame_ref_step_q <= step_code(fr_d);
    end
  end

  // ================================================================
  // read port: answer one cycle after reg_rd_en; writes are dropped,
  // so reg_wr_data steers nothing and reg_wr_en only withholds reg_rd_valid_q
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    if (reg_addr == `PTSS_OFF_CAP_BANK) begin
      rd_mux = cap_bank_q;
    end else if (reg_addr == `PTSS_OFF_ERR_LOW) begin
      rd_mux = err_count_q[7:0];
    end else if (reg_addr == `PTSS_OFF_TUNE_STATUS) begin
      rd_mux = {live_q.busy, err_sign_q, err_count_q[13:8]};
    end else if (reg_addr == `PTSS_OFF_FSM_STATE) begin
      rd_mux = {live_q.tune_state, live_q.sync_state};
    end else if (reg_addr == `PTSS_OFF_FRAME_REF) begin
      rd_mux = {3'h0, ch_busy_q, frame_ref_step_q};
    end else begin
      rd_mux = 8'h00; // reserved byte and unmapped addresses
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rd_data_q <= `PTSS_RST_BYTE;
      reg_rd_valid_q <= 1'b0;
    end else begin
      reg_rd_valid_q <= reg_rd_en && !reg_wr_en;
      if (reg_rd_en) begin
        reg_rd_data_q <= rd_mux;
      end
    end
  end

endmodule

/* File: inc/ptss_map.svh */
// register offsets, field positions, reset values and timing counts for
// the second loop pll tune and frame reference status registers.
// assumes byte-wide registers on a 16-bit register address.
`ifndef PTSS_MAP_SVH
`define PTSS_MAP_SVH

// ==================================================================
// register offsets
`define PTSS_OFF_CAP_BANK 16'h008c
`define PTSS_OFF_ERR_LOW 16'h008d
`define PTSS_OFF_TUNE_STATUS 16'h008e
`define PTSS_OFF_FSM_STATE 16'h008f
`define PTSS_OFF_RESERVED 16'h0090
`define PTSS_OFF_FRAME_REF 16'h0091

// ==================================================================
// field positions
`define PTSS_BIT_TUNE_BUSY 7
`define PTSS_BIT_ERR_SIGN 6
`define PTSS_BIT_CH_BUSY 4

// ==================================================================
// reset values
`define PTSS_RST_BYTE 8'h00
`define PTSS_RST_ERR 14'h0000

// ==================================================================
// frame reference step codes as read back
`define PTSS_CODE_RESET 4'h0
`define PTSS_CODE_DONE 4'h2
`define PTSS_CODE_GET0 4'h4
`define PTSS_CODE_GET1 4'h5
`define PTSS_CODE_GET2 4'h6
`define PTSS_CODE_RUN 4'ha
`define PTSS_CODE_START 4'hb
`define PTSS_CODE_PWR0 4'hc
`define PTSS_CODE_PWR1 4'hd
`define PTSS_CODE_PWR2 4'he
`define PTSS_CODE_CLEAR 4'hf

// ==================================================================
// timing: core_clk cycles between two frame reference sequencer steps
`define PTSS_STEP_DIV 8

`endif

/* File: inc/ptss_pkg.sv */
// types shared by the tune and frame reference status registers.
// assumes ptss_map.svh sits on the include path.
package ptss_pkg;

  // ================================================================
  // frame reference sequencer states, one-hot
  typedef enum logic [10:0] {
    FR_RESET = 11'b000_0000_0001,
    FR_DONE = 11'b000_0000_0010,
    FR_GET0 = 11'b000_0000_0100,
    FR_GET1 = 11'b000_0000_1000,
    FR_GET2 = 11'b000_0001_0000,
    FR_RUN = 11'b000_0010_0000,
    FR_START = 11'b000_0100_0000,
    FR_PWR0 = 11'b000_1000_0000,
    FR_PWR1 = 11'b001_0000_0000,
    FR_PWR2 = 11'b010_0000_0000,
    FR_CLEAR = 11'b100_0000_0000
  } ptss_fr_state_t;

  // which trigger started the running progression
  typedef enum logic [2:0] {
    TRIG_RESEED = 3'b001,
    TRIG_PULSE = 3'b010,
    TRIG_RSVD = 3'b100
  } ptss_trig_t;

  // result of one autotune run, as handed over by the tune engine
  typedef struct packed {
    logic [7:0] cap_bank;
    logic err_sign;
    logic [13:0] err_count;
  } ptss_tune_result_t;

  // live status from the tune and sync-carry engines
  typedef struct packed {
    logic busy;
    logic [3:0] tune_state;
    logic [3:0] sync_state;
  } ptss_tune_live_t;

endpackage

/* File: testbench/ptss_regs_monitor.sv */
// checker for the tune and frame reference status registers.
// assumes it is bound onto ptss_regs and sees only its ports.
`timescale 1ns/100ps
module ptss_regs_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reg_rd_en,
  input wire logic reg_wr_en,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data_q,
  input wire logic reg_rd_valid_q,
  input wire logic tune_done,
  input wire ptss_pkg::ptss_tune_result_t tune_result,
  input wire ptss_pkg::ptss_tune_live_t tune_live,
  input wire logic channel_busy,
  input wire logic reseed_req,
  input wire logic pulse_req,
  input wire logic rsvd_req,
  input wire logic pulse_finished,
  input wire logic [3:0] frame_ref_step_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ptss_pkg::ptss_tune_result_t cap_q;
  logic rd;
  logic any_req;
  // =================================================================
  // shadow of the last capture; reads racing a capture are skipped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cap_q <= '0;
    end else if (tune_done) begin
      cap_q <= tune_result;
    end
  end
  // plain read strobe, write-collided reads excluded
  assign rd = reg_rd_en && !reg_wr_en && !tune_done;
  assign any_req = reseed_req || pulse_req || rsvd_req;
  property p_cap_bank;
    rd && reg_addr == 16'h008c |=> reg_rd_data_q == cap_q.cap_bank;
  endproperty
  a_cap_bank: assert property (p_cap_bank) else $error("cap bank read");
  property p_err_low;
    rd && reg_addr == 16'h008d |=> reg_rd_data_q == cap_q.err_count[7:0];
  endproperty
  a_err_low: assert property (p_err_low) else $error("error low read");
  // live fields lag two edges, so a read just after reset is skipped
  property p_err_high;
    rd && !$past(rst) && reg_addr == 16'h008e |=> reg_rd_data_q ==
      {$past(tune_live.busy, 2), cap_q.err_sign, cap_q.err_count[13:8]};
  endproperty
  a_err_high: assert property (p_err_high) else $error("status read");
  property p_states;
    rd && !$past(rst) && reg_addr == 16'h008f |=> reg_rd_data_q ==
      {$past(tune_live.tune_state, 2), $past(tune_live.sync_state, 2)};
  endproperty
  a_states: assert property (p_states) else $error("state read");
  property p_frame_ref;
    rd && !$past(rst) && reg_addr == 16'h0091 |=> reg_rd_data_q ==
      {3'h0, $past(channel_busy, 2), $past(frame_ref_step_q)};
  endproperty
  a_frame_ref: assert property (p_frame_ref) else $error("frame");
  property p_seq_start;
    frame_ref_step_q == 4'h0 && any_req |=> frame_ref_step_q == 4'h4;
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("no start");
  property p_seq_idle;
    frame_ref_step_q == 4'h0 && !any_req |=> $stable(frame_ref_step_q);
  endproperty
  a_seq_idle: assert property (p_seq_idle) else $error("idle moved");
  property p_rsvd;
    rd && reg_addr == 16'h0090 |=> reg_rd_data_q == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read");
  property p_wr_refused;
    reg_rd_en && reg_wr_en |=> !reg_rd_valid_q;
  endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("wr valid");
endmodule
bind ptss_regs ptss_regs_monitor mon (.*);

/* File: testbench/tb_top.sv */
// self-checking bench for ptss_regs: register reads and sequencer runs.
// assumes the design and package compile first, ptss_map.svh on path.
`timescale 1ns/100ps
`include "ptss_map.svh"
module tb_top;
  logic core_clk = 0, rst = 1, rd_en = 0, wr_en = 0, tdone = 0;
  logic ch_busy = 0, reseed = 0, pulse = 0, rsvd = 0, pfin = 0;
  logic [15:0] addr = '0;
  logic [7:0] wdata = '0, rdata;
  logic valid;
  logic [3:0] step, last;
  logic [39:0] seen;
  ptss_pkg::ptss_tune_result_t tres = '0;
  ptss_pkg::ptss_tune_live_t tlive = '0;
  int fails = 0, tests_run = 0;
  always #20 core_clk = ~core_clk;
  // short step divider keeps each progression brief
  ptss_regs #(.STEP_DIV(2)) dut (.core_clk(core_clk), .rst(rst),
    .reg_rd_en(rd_en), .reg_wr_en(wr_en), .reg_addr(addr),
    .reg_wr_data(wdata), .reg_rd_data_q(rdata), .reg_rd_valid_q(valid),
    .tune_done(tdone), .tune_result(tres), .tune_live(tlive),
    .channel_busy(ch_busy), .reseed_req(reseed), .pulse_req(pulse),
    .rsvd_req(rsvd), .pulse_finished(pfin), .frame_ref_step_q(step));
  // =================================================================
  // helpers
  task automatic chk(input string n, input logic [39:0] e, g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    rd_en <= 1;
    addr <= a;
    @(posedge core_clk);
    rd_en <= 0;
    #1;
    chk("valid", 40'h1, {39'h0, valid});
    chk($sformatf("reg %h", a), {32'h0, e}, {32'h0, rdata});
  endtask
  // one progression; a stray trigger in step 5 must be ignored
  task automatic run(input logic [2:0] r, input logic [39:0] e);
    seen = '0;
    last = 4'h0;
    @(posedge core_clk);
    {reseed, pulse, rsvd} <= r;
    @(posedge core_clk);
    {reseed, pulse, rsvd} <= 3'b000;
    for (int i = 0; i < 200; i++) begin
      #1;
      if (step !== last) seen = {seen[35:0], step};
      last = step;
      if (step === 4'h0) break;
      @(posedge core_clk);
      reseed <= (step == 4'h5);
      pfin <= (step == 4'ha);
    end
    // release the side inputs on an edge, never between edges
    @(posedge core_clk);
    reseed <= 0;
    pfin <= 0;
    chk("step order", e, seen);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // =================================================================
  // watchdog
  initial begin
    #200000;
    fails++;
    close_out();
  end
  // =================================================================
  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 0;
    for (int a = 16'h8c; a <= 16'h91; a++) rd(a[15:0], 8'h00);
    @(posedge core_clk);
    tres <= '{cap_bank: 8'ha5, err_sign: 1'b1, err_count: 14'h2d3c};
    tlive <= '{busy: 1'b1, tune_state: 4'h9, sync_state: 4'h7};
    ch_busy <= 1;
    tdone <= 1;
    @(posedge core_clk);
    tdone <= 0;
    tres <= '0;
    rd(`PTSS_OFF_CAP_BANK, 8'ha5);
    rd(`PTSS_OFF_ERR_LOW, 8'h3c);
    rd(`PTSS_OFF_TUNE_STATUS, 8'hed);
    rd(`PTSS_OFF_FSM_STATE, 8'h97);
    rd(`PTSS_OFF_FRAME_REF, 8'h10);
    // a write colliding with a read must withhold valid and leave the cap bank as it was
    @(posedge core_clk);
    wr_en <= 1;
    wdata <= 8'hff;
    addr <= `PTSS_OFF_CAP_BANK;
    rd_en <= 1;
    @(posedge core_clk);
    {wr_en, rd_en} <= 2'b00;
    #1;
    chk("collided valid", 40'h0, {39'h0, valid});
    rd(`PTSS_OFF_CAP_BANK, 8'ha5);
    // a plain write returns nothing and leaves the error byte alone
    @(posedge core_clk);
    wr_en <= 1;
    addr <= `PTSS_OFF_ERR_LOW;
    @(posedge core_clk);
    wr_en <= 0;
    #1;
    chk("write valid", 40'h0, {39'h0, valid});
    rd(`PTSS_OFF_ERR_LOW, 8'h3c);
    @(posedge core_clk);
    tlive <= '{busy: 1'b0, tune_state: 4'hb, sync_state: 4'he};
    ch_busy <= 0;
    rd(`PTSS_OFF_RESERVED, 8'h00);
    rd(`PTSS_OFF_FSM_STATE, 8'hbe);
    rd(`PTSS_OFF_TUNE_STATUS, 8'h6d);
    rd(`PTSS_OFF_FRAME_REF, 8'h00);
    run(3'b100, 40'h456cdefb20);
    run(3'b011, 40'h456ba20);
    run(3'b001, 40'h45620);
    // reset in mid progression: sequencer and captures return to rest
    @(posedge core_clk);
    reseed <= 1;
    @(posedge core_clk);
    reseed <= 0;
    repeat (4) @(posedge core_clk);
    rst <= 1;
    @(posedge core_clk);
    rst <= 0;
    #1;
    chk("step after reset", 40'h0, {36'h0, step});
    rd(`PTSS_OFF_CAP_BANK, 8'h00);
    rd(`PTSS_OFF_TUNE_STATUS, 8'h00);
    rd(`PTSS_OFF_FSM_STATE, 8'hbe);
    rd(`PTSS_OFF_FRAME_REF, 8'h00);
    run(3'b001, 40'h45620);
    close_out();
  end
endmodule
